// File: core/fpmc_ctrl.sv
// flash bank and pump power mode controller with its configuration registers
`timescale 1ns/10ps
`include "fpmc_regs.svh"
module fpmc_ctrl
  import fpmc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire fpmc_req_t req,
  output logic [15:0] rdata,
  // protection
  input wire logic protected_write_enable,
  input wire logic security_locked,
  // pump interface
  input wire logic supply_out_of_range,
  output logic [1:0] bank_pump_mode
);

// ----------------------------------------------------------------
// decode
// ----------------------------------------------------------------
wire logic access_ok = !security_locked;
wire logic wr_ok = req.wr && access_ok && protected_write_enable;
wire logic wr_request = wr_ok && (req.addr == `FPMC_OFS_REQUEST);
wire logic wr_status = wr_ok && (req.addr == `FPMC_OFS_STATUS);
wire logic wr_stby = wr_ok && (req.addr == `FPMC_OFS_STBY_WAIT);
wire logic wr_wake = wr_ok && (req.addr == `FPMC_OFS_WAKE_WAIT);
wire logic [1:0] wr_mode = req.wdata[`FPMC_MODE_LSB +: 2];
wire logic mode_valid = (wr_mode != FPMC_RSVD);

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
logic [1:0] request_reg;
logic [1:0] current_reg;
logic [8:0] stby_wait_reg;
logic [8:0] wake_wait_reg;
logic [8:0] count_reg;
logic fault_reg;
fpmc_state_t state_reg;
fpmc_state_t state_next;
logic [8:0] count_next;
logic [1:0] current_next;

wire logic fault_clr = wr_status && req.wdata[`FPMC_FAULT_BIT];
wire logic fault_next = supply_out_of_range | (fault_reg & ~fault_clr);

always_ff @(posedge clk or posedge rst) begin
  if (rst) begin
    request_reg <= `FPMC_REQUEST_RST;
    stby_wait_reg <= `FPMC_WAIT_RST;
    wake_wait_reg <= `FPMC_WAIT_RST;
    fault_reg <= 1'b0;
  end else begin
    if (wr_request && mode_valid) begin
      request_reg <= wr_mode;
    end
    if (wr_stby) begin
      stby_wait_reg <= req.wdata[`FPMC_WAIT_LSB +: `FPMC_WAIT_W];
    end
    if (wr_wake) begin
      wake_wait_reg <= req.wdata[`FPMC_WAIT_LSB +: `FPMC_WAIT_W];
    end
    fault_reg <= fault_next;
  end
end

// ----------------------------------------------------------------
// transition sequencer
// ----------------------------------------------------------------
wire logic count_done = (count_reg == 9'h000);

always_comb begin
  state_next = state_reg;
  count_next = count_reg;
  current_next = current_reg;
  case (state_reg)
    FPMC_ST_IDLE: begin
      if (request_reg != current_reg) begin
        if (request_reg == FPMC_SLEEP) begin
          current_next = FPMC_SLEEP;
        end else if (current_reg == FPMC_SLEEP) begin
          state_next = FPMC_ST_STBY;
          count_next = stby_wait_reg;
        end else if (request_reg == FPMC_ACTIVE) begin
          state_next = FPMC_ST_WAKE;
          count_next = wake_wait_reg;
        end else begin
          current_next = FPMC_STANDBY;
        end
      end
    end
    FPMC_ST_STBY: begin
      if (request_reg == FPMC_SLEEP) begin
        state_next = FPMC_ST_IDLE;
        current_next = FPMC_SLEEP;
      end else if (count_done) begin
        current_next = FPMC_STANDBY;
        if (request_reg == FPMC_ACTIVE) begin
          state_next = FPMC_ST_WAKE;
          count_next = wake_wait_reg;
        end else begin
          state_next = FPMC_ST_IDLE;
        end
      end else begin
        count_next = count_reg - 9'h001;
      end
    end
    FPMC_ST_WAKE: begin
      if (request_reg != FPMC_ACTIVE) begin
        state_next = FPMC_ST_IDLE;
        if (request_reg == FPMC_SLEEP) begin
          current_next = FPMC_SLEEP;
        end
      end else if (count_done) begin
        current_next = FPMC_ACTIVE;
        state_next = FPMC_ST_IDLE;
      end else begin
        count_next = count_reg - 9'h001;
      end
    end
    default: begin
      state_next = FPMC_ST_IDLE;
    end
  endcase
end

always_ff @(posedge clk or posedge rst) begin
  if (rst) begin
    state_reg <= FPMC_ST_IDLE;
    count_reg <= 9'h000;
    current_reg <= FPMC_SLEEP;
  end else begin
    state_reg <= state_next;
    count_reg <= count_next;
    current_reg <= current_next;
  end
end

// ----------------------------------------------------------------
// read path
// ----------------------------------------------------------------
wire logic stby_running = (state_reg == FPMC_ST_STBY);
wire logic wake_running = (state_reg == FPMC_ST_WAKE);
wire logic [15:0] status_word = {7'h00, fault_reg, 4'h0, wake_running, stby_running,
  current_reg};
wire logic [15:0] rd_word =
  (req.addr == `FPMC_OFS_REQUEST) ? {14'h0000, request_reg} :
  (req.addr == `FPMC_OFS_STATUS) ? status_word :
  (req.addr == `FPMC_OFS_STBY_WAIT) ? {7'h00, stby_wait_reg} :
  (req.addr == `FPMC_OFS_WAKE_WAIT) ? {7'h00, wake_wait_reg} :
  16'h0000;

always_ff @(posedge clk or posedge rst) begin
  if (rst) begin
    rdata <= 16'h0000;
  end else if (req.rd && access_ok) begin
    rdata <= rd_word;
  end else begin
    rdata <= 16'h0000;
  end
end

assign bank_pump_mode = current_reg;

endmodule

// File: core/fpmc_regs.svh
// register offsets, field positions, reset values and timing counts for the flash power block
`ifndef FPMC_REGS_SVH
`define FPMC_REGS_SVH
`define FPMC_ADDR_W 3
`define FPMC_OFS_REQUEST 3'h2
`define FPMC_OFS_STATUS 3'h3
`define FPMC_OFS_STBY_WAIT 3'h4
`define FPMC_OFS_WAKE_WAIT 3'h5
`define FPMC_MODE_LSB 0
`define FPMC_STBY_RUN_BIT 2
`define FPMC_WAKE_RUN_BIT 3
`define FPMC_FAULT_BIT 8
`define FPMC_WAIT_LSB 0
`define FPMC_WAIT_W 9
`define FPMC_REQUEST_RST 2'h0
`define FPMC_WAIT_RST 9'h1ff
`endif

// File: core/fpmc_pkg.sv
// types for the flash power mode controller
package fpmc_pkg;
  typedef enum logic [1:0] {
    FPMC_SLEEP = 2'h0,
    FPMC_STANDBY = 2'h1,
    FPMC_RSVD = 2'h2,
    FPMC_ACTIVE = 2'h3
  } fpmc_mode_t;
  typedef enum logic [2:0] {
    FPMC_ST_IDLE = 3'h1,
    FPMC_ST_STBY = 3'h2,
    FPMC_ST_WAKE = 3'h4
  } fpmc_state_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [15:0] wdata;
  } fpmc_req_t;
endpackage

// File: tb/fpmc_ctrl_props.sv
// port assertions for fpmc_ctrl
`timescale 1ns/10ps
module fpmc_ctrl_props
  import fpmc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // design ports
  input wire fpmc_req_t req,
  input wire logic [15:0] rdata,
  input wire logic protected_write_enable,
  input wire logic security_locked,
  input wire logic supply_out_of_range,
  input wire logic [1:0] bank_pump_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire rd_ok = req.rd && !security_locked;
  wire wr_ok = req.wr && req.addr == 3'h2 && protected_write_enable && !security_locked;
  AST_LOCK_RD: assert property (req.rd && security_locked |=> rdata == 16'h0000)
    else $error("locked read gave data");
  AST_FAULT: assert property (supply_out_of_range ##1 rd_ok && req.addr == 3'h3 |=> rdata[8])
    else $error("fault latch not set");
  AST_NO_RSVD: assert property (bank_pump_mode != 2'h2)
    else $error("reserved mode");
  AST_NO_JUMP: assert property ($past(bank_pump_mode) == 2'h0 |-> bank_pump_mode != 2'h3)
    else $error("sleep to active jump");
  AST_WAIT: assert property (wr_ok && req.wdata[1:0] == 2'h1 && bank_pump_mode == 2'h0
    |=> bank_pump_mode == 2'h0)
    else $error("standby without wait");
  AST_SLEEP: assert property (wr_ok && req.wdata[1:0] == 2'h0 |-> ##[1:2] bank_pump_mode == 2'h0)
    else $error("sleep not taken");
  AST_STATUS: assert property (rd_ok && req.addr == 3'h3
    |=> rdata[1:0] == $past(bank_pump_mode) && rdata[7:4] == 4'h0)
    else $error("status mode wrong");
  AST_WAIT_REG: assert property (rd_ok && req.addr == 3'h4 |=> rdata[15:9] == 7'h00)
    else $error("wait reserved bits set");
endmodule
bind fpmc_ctrl fpmc_ctrl_props u_props (.clk, .rst, .req, .rdata, .protected_write_enable,
  .security_locked, .supply_out_of_range, .bank_pump_mode);

// File: tb/fpmc_ctrl_tb.sv
// self-checking bench for fpmc_ctrl
`timescale 1ns/10ps
module fpmc_ctrl_tb
  import fpmc_pkg::*;
;
  logic clk = 0, rst = 1, pwe = 1, lock = 0, sup = 0;
  fpmc_req_t req = '0;
  logic [15:0] rdata;
  logic [1:0] mode;
  int errors = 0, comparisons = 0;
  always #20 clk = ~clk;
  fpmc_ctrl dut (.clk, .rst, .req, .rdata, .protected_write_enable(pwe),
    .security_locked(lock), .supply_out_of_range(sup), .bank_pump_mode(mode));
  task automatic close_out;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clk) req.wr = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] x);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk) req.rd = 1'b0;
    comparisons++;
    if (rdata !== x) begin
      errors++;
      $display("[FAIL] %0t addr %h got %h want %h", $time, a, rdata, x);
    end
    @(negedge clk);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst = 0;
    rd(3'h4, 16'h01ff);
    rd(3'h5, 16'h01ff);
    rd(3'h7, 16'h0000);
    wr(3'h4, 16'h0003);
    wr(3'h5, 16'h0002);
    rd(3'h4, 16'h0003);
    wr(3'h2, 16'h0003);
    rd(3'h3, 16'h0004);
    repeat (2) @(negedge clk);
    rd(3'h3, 16'h0009);
    repeat (4) @(negedge clk);
    rd(3'h3, 16'h0003);
    sup = 1;
    @(negedge clk) sup = 0;
    rd(3'h3, 16'h0103);
    wr(3'h3, 16'h0000);
    rd(3'h3, 16'h0103);
    wr(3'h3, 16'h0100);
    rd(3'h3, 16'h0003);
    wr(3'h2, 16'h0002);
    rd(3'h2, 16'h0003);
    pwe = 0;
    wr(3'h2, 16'h0000);
    pwe = 1;
    rd(3'h3, 16'h0003);
    lock = 1;
    rd(3'h3, 16'h0000);
    wr(3'h2, 16'h0000);
    lock = 0;
    rd(3'h3, 16'h0003);
    wr(3'h2, 16'h0000);
    rd(3'h3, 16'h0000);
    wr(3'h2, 16'h0001);
    rd(3'h3, 16'h0004);
    repeat (4) @(negedge clk);
    rd(3'h3, 16'h0001);
    close_out;
  end
  initial begin
    repeat (400) @(posedge clk);
    errors++;
    close_out;
  end
endmodule
